// *** include/pvc_pkg.sv ***
package pvc_pkg;

    // ************************************************************
    // source layout
    // ************************************************************
    localparam int NUM_INT = 14;
    localparam int EXT0_IDX = 14;
    localparam int EXT1_IDX = 15;
    localparam int NUM_NORM = 16;
    localparam int FAST_IDX = 16;
    localparam int NUM_SRC = 17;
    localparam int PRIO_W = 3;
    localparam int IDX_W = 4;
    localparam int MODE_W = 6;

    // ************************************************************
    // address window
    // ************************************************************
    localparam logic [11:0] TOP_MB_TAG = 12'hfff;
    localparam logic [5:0] WIN_SEL = 6'h20;
    localparam logic [5:0] REG_PAGE = 6'h3f;

    // ************************************************************
    // register offsets inside the register page
    // ************************************************************
    localparam logic [7:0] OFS_MODE_FIRST = 8'h00;
    localparam logic [7:0] OFS_MODE_LAST = 8'h40;
    localparam logic [7:0] OFS_VEC = 8'h44;
    localparam logic [7:0] OFS_PEND = 8'h48;
    localparam logic [7:0] OFS_PEND_SET = 8'h4c;
    localparam logic [7:0] OFS_PEND_CLR = 8'h50;
    localparam logic [7:0] OFS_EN = 8'h54;
    localparam logic [7:0] OFS_EN_SET = 8'h58;
    localparam logic [7:0] OFS_EN_CLR = 8'h5c;

    // ************************************************************
    // fields
    // ************************************************************
    localparam int MODE_PRIO_LSB = 0;
    localparam int MODE_POL_BIT = 4;
    localparam int MODE_EDGE_BIT = 5;
    localparam logic [MODE_W-1:0] MODE_MASK = 6'h37;
    localparam logic [MODE_W-1:0] MODE_RESET = 6'h00;
    localparam int VEC_IDX_LSB = 0;
    localparam int VEC_LEVEL_LSB = 4;
    localparam int VEC_VALID_BIT = 31;
    localparam int MODE_IDX_LSB = 2;

    // mode[5:4]: edge select, polarity / direction
    typedef enum logic [1:0] {
        PVC_LOW_LEVEL = 2'b00,
        PVC_HIGH_LEVEL = 2'b01,
        PVC_FALL_EDGE = 2'b10,
        PVC_RISE_EDGE = 2'b11
    } pvc_mode_e;

    typedef enum logic [3:0] {
        PVC_REG_NONE = 4'h0,
        PVC_REG_MODE = 4'h1,
        PVC_REG_VEC = 4'h3,
        PVC_REG_PEND = 4'h2,
        PVC_REG_PEND_SET = 4'h6,
        PVC_REG_PEND_CLR = 4'h7,
        PVC_REG_EN = 4'h5,
        PVC_REG_EN_SET = 4'h4,
        PVC_REG_EN_CLR = 4'hc
    } pvc_reg_e;

endpackage

// *** rtl/pvc_src_cond.sv ***
`timescale 1ns/100ps
module pvc_src_cond import pvc_pkg::*; (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic raw,
    input wire logic edge_mode,
    input wire logic active_high,
    output logic hit
);

    logic prev;
    logic next_prev;
    logic norm;
    logic norm_prev;

    // ************************************************************
    // polarity and sensitivity
    // ************************************************************
    always_comb begin
        norm = active_high ? raw : ~raw;
        norm_prev = active_high ? prev : ~prev;
        next_prev = raw;
        if (edge_mode) begin
            hit = norm & ~norm_prev;
        end else begin
            hit = norm;
        end
    end

    // prev tracks the pin even in level mode, so a switch to edge
    // mode does not fire on a stale history
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prev <= 1'b0;
        end else if (ce) begin
            prev <= next_prev;
        end
    end

endmodule

// *** rtl/pvc_prio_enc.sv ***
`timescale 1ns/100ps
module pvc_prio_enc import pvc_pkg::*; (
    input wire logic [NUM_NORM-1:0] req,
    input wire logic [NUM_NORM*PRIO_W-1:0] prio_flat,
    output logic valid,
    output logic [IDX_W-1:0] idx,
    output logic [PRIO_W-1:0] level
);

    // strict greater-than: ties keep the lower index found first
    always_comb begin
        valid = 1'b0;
        idx = '0;
        level = '0;
        for (int i = 0; i < NUM_NORM; i++) begin
            if (req[i] && (!valid || prio_flat[i*PRIO_W +: PRIO_W] > level)) begin
                valid = 1'b1;
                idx = IDX_W'(i);
                level = prio_flat[i*PRIO_W +: PRIO_W];
            end
        end
    end

endmodule

// *** rtl/pvc_top.sv ***
`timescale 1ns/100ps
module pvc_top import pvc_pkg::*; (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NUM_INT-1:0] periph_irq,
    input wire logic ext_request_pin_zero,
    input wire logic ext_request_pin_one,
    input wire logic fast_request_pin,
    output logic core_fast_request_n,
    output logic core_normal_request_n,
    output logic irq
);

    // ************************************************************
    // address decode
    // ************************************************************
    function automatic pvc_reg_e decode(input logic [31:0] a);
        pvc_reg_e k;
        k = PVC_REG_NONE;
        if (a[31:20] == TOP_MB_TAG && a[19:14] == WIN_SEL && a[13:8] == REG_PAGE && a[1:0] == 2'h0) begin
            if (a[7:0] >= OFS_MODE_FIRST && a[7:0] <= OFS_MODE_LAST) begin
                k = PVC_REG_MODE;
            end else begin
                unique case (a[7:0])
                    OFS_VEC: k = PVC_REG_VEC;
                    OFS_PEND: k = PVC_REG_PEND;
                    OFS_PEND_SET: k = PVC_REG_PEND_SET;
                    OFS_PEND_CLR: k = PVC_REG_PEND_CLR;
                    OFS_EN: k = PVC_REG_EN;
                    OFS_EN_SET: k = PVC_REG_EN_SET;
                    OFS_EN_CLR: k = PVC_REG_EN_CLR;
                    default: k = PVC_REG_NONE;
                endcase
            end
        end
        return k;
    endfunction

    logic [NUM_SRC-1:0] src_raw;
    logic [NUM_SRC-1:0] src_hit;
    logic [MODE_W-1:0] src_mode [NUM_SRC];
    logic [MODE_W-1:0] next_src_mode [NUM_SRC];
    logic [NUM_SRC-1:0] pending;
    logic [NUM_SRC-1:0] next_pending;
    logic [NUM_SRC-1:0] enable;
    logic [NUM_SRC-1:0] next_enable;
    logic [NUM_NORM*PRIO_W-1:0] prio_flat;
    logic [NUM_NORM-1:0] req;
    logic enc_valid;
    logic [IDX_W-1:0] enc_idx;
    logic [PRIO_W-1:0] enc_level;
    logic vec_valid;
    logic [IDX_W-1:0] vec_idx;
    logic [PRIO_W-1:0] vec_level;
    logic next_vec_valid;
    logic [IDX_W-1:0] next_vec_idx;
    logic [PRIO_W-1:0] next_vec_level;
    logic next_core_fast_request_n;
    logic next_core_normal_request_n;
    logic next_irq;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    pvc_reg_e rd_kind;
    pvc_reg_e wr_kind;
    logic wr_done;
    logic [4:0] mode_sel;
    logic [NUM_SRC-1:0] wr_bits;

    assign src_raw = {fast_request_pin, ext_request_pin_one, ext_request_pin_zero, periph_irq};
    assign mode_sel = paddr[MODE_IDX_LSB +: 5];
    assign wr_bits = pwdata[NUM_SRC-1:0];
    assign req = pending[NUM_NORM-1:0] & enable[NUM_NORM-1:0];

    // ************************************************************
    // source conditioning
    // ************************************************************
    generate
        for (genvar g = 0; g < NUM_SRC; g++) begin : g_src
            // internal sources have no polarity choice: always active high
            pvc_src_cond u_cond (
                .ref_clk(ref_clk),
                .rst_n(rst_n),
                .ce(ce),
                .raw(src_raw[g]),
                .edge_mode(src_mode[g][MODE_EDGE_BIT]),
                .active_high((g < NUM_INT) ? 1'b1 : src_mode[g][MODE_POL_BIT]),
                .hit(src_hit[g])
            );
            if (g < NUM_NORM) begin : g_prio
                assign prio_flat[g*PRIO_W +: PRIO_W] = src_mode[g][MODE_PRIO_LSB +: PRIO_W];
            end
        end
    endgenerate

    pvc_prio_enc u_enc (
        .req(req),
        .prio_flat(prio_flat),
        .valid(enc_valid),
        .idx(enc_idx),
        .level(enc_level)
    );

    // ************************************************************
    // apb slave
    // ************************************************************
    // pready is raised from the setup cycle, so every access has no
    // wait state while all bus outputs still come from flops
    always_comb begin
        rd_kind = decode(paddr);
        next_pready = psel & ~penable;
        next_pslverr = 1'b0;
        next_prdata = '0;
        if (psel && !penable) begin
            next_pslverr = (rd_kind == PVC_REG_NONE);
            if (!pwrite) begin
                unique case (rd_kind)
                    PVC_REG_MODE: next_prdata = 32'(src_mode[mode_sel]);
                    PVC_REG_VEC: begin
                        next_prdata[VEC_IDX_LSB +: IDX_W] = vec_idx;
                        next_prdata[VEC_LEVEL_LSB +: PRIO_W] = vec_level;
                        next_prdata[VEC_VALID_BIT] = vec_valid;
                    end
                    PVC_REG_PEND: next_prdata = 32'(pending);
                    PVC_REG_EN: next_prdata = 32'(enable);
                    default: next_prdata = '0;
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (ce) begin
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    assign wr_kind = decode(paddr);
    assign wr_done = psel & penable & pready & pwrite & ~pslverr;

    // ************************************************************
    // mode, enable and pending state
    // ************************************************************
    always_comb begin
        for (int i = 0; i < NUM_SRC; i++) begin
            next_src_mode[i] = src_mode[i];
        end
        if (wr_done && wr_kind == PVC_REG_MODE) begin
            next_src_mode[mode_sel] = pwdata[MODE_W-1:0] & MODE_MASK;
        end
        next_enable = enable;
        if (wr_done && wr_kind == PVC_REG_EN_SET) begin
            next_enable = enable | wr_bits;
        end
        if (wr_done && wr_kind == PVC_REG_EN_CLR) begin
            next_enable = enable & ~wr_bits;
        end
        for (int i = 0; i < NUM_SRC; i++) begin
            if (src_mode[i][MODE_EDGE_BIT]) begin
                // sticky; a new edge beats a clear in the same cycle
                next_pending[i] = src_hit[i]
                    | (wr_done && wr_kind == PVC_REG_PEND_SET && wr_bits[i])
                    | (pending[i] & ~(wr_done && wr_kind == PVC_REG_PEND_CLR && wr_bits[i]));
            end else begin
                // level sources follow the line; software cannot override
                next_pending[i] = src_hit[i];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_SRC; i++) begin
                src_mode[i] <= MODE_RESET;
            end
            enable <= '0;
            pending <= '0;
        end else if (ce) begin
            src_mode <= next_src_mode;
            enable <= next_enable;
            pending <= next_pending;
        end
    end

    // ************************************************************
    // core requests and vector
    // ************************************************************
    always_comb begin
        next_vec_valid = enc_valid;
        next_vec_idx = enc_idx;
        next_vec_level = enc_level;
        next_irq = |req;
        next_core_normal_request_n = ~(|req);
        next_core_fast_request_n = ~(pending[FAST_IDX] & enable[FAST_IDX]);
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            vec_valid <= 1'b0;
            vec_idx <= '0;
            vec_level <= '0;
            irq <= 1'b0;
            core_normal_request_n <= 1'b1;
            core_fast_request_n <= 1'b1;
        end else if (ce) begin
            vec_valid <= next_vec_valid;
            vec_idx <= next_vec_idx;
            vec_level <= next_vec_level;
            irq <= next_irq;
            core_normal_request_n <= next_core_normal_request_n;
            core_fast_request_n <= next_core_fast_request_n;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    logic prio_beaten;

    always_comb begin
        prio_beaten = 1'b0;
        for (int j = 0; j < NUM_NORM; j++) begin
            if (req[j] && (prio_flat[j*PRIO_W +: PRIO_W] > enc_level
                || (prio_flat[j*PRIO_W +: PRIO_W] == enc_level && IDX_W'(j) < enc_idx))) begin
                prio_beaten = 1'b1;
            end
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_fast_rise;
        ce && !fast_request_pin ##1 ce && fast_request_pin
            && src_mode[FAST_IDX][MODE_EDGE_BIT:MODE_POL_BIT] == PVC_RISE_EDGE;
    endsequence

    sequence s_fast_seen;
        pending[FAST_IDX] ##1 !core_fast_request_n;
    endsequence

    a_prio_highest_win:
    assert property (enc_valid |-> !prio_beaten)
        else $error("a lower or equal-later source won arbitration");

    a_vector_follows:
    assert property (ce && enc_valid |=> vec_valid && vec_idx == $past(enc_idx) && vec_level == $past(enc_level))
        else $error("vector does not name the winning source");

    a_mask_blocks_all:
    assert property (ce && req == '0 |=> core_normal_request_n && !irq && !vec_valid)
        else $error("normal request raised with nothing enabled and pending");

    a_fast_only_pin:
    assert property (ce && !(pending[FAST_IDX] && enable[FAST_IDX]) |=> core_fast_request_n)
        else $error("fast request without fast pin event");

    a_fast_edge_path:
    assert property (s_fast_rise ##0 enable[FAST_IDX] ##1 ce |-> s_fast_seen)
        else $error("fast rising edge did not reach the core");

    a_normal_from_req:
    assert property (ce && |req |=> !core_normal_request_n && irq)
        else $error("pending enabled source did not raise normal request");

    a_enable_set_alias:
    assert property (ce && wr_done && wr_kind == PVC_REG_EN_SET |=> enable == ($past(enable) | $past(wr_bits)))
        else $error("enable set alias did not or in the written ones");

    a_enable_clr_alias:
    assert property (ce && wr_done && wr_kind == PVC_REG_EN_CLR |=> enable == ($past(enable) & ~$past(wr_bits)))
        else $error("enable clear alias did not drop the written ones");

    a_level_tracks_pin:
    assert property (ce && !src_mode[0][MODE_EDGE_BIT] |=> pending[0] == $past(periph_irq[0]))
        else $error("level source pending does not track its line");

    a_edge_beats_clr:
    assert property (ce && src_mode[0][MODE_EDGE_BIT] && src_hit[0] |=> pending[0])
        else $error("edge event lost");

    a_window_refuse:
    assert property (ce && psel && !penable && decode(paddr) == PVC_REG_NONE |=> pready && pslverr)
        else $error("access outside register page not refused");

endmodule

// *** tb/pvc_core_model.sv ***
`timescale 1ns/100ps
// ************************************************************
// core side: counts each new request on the two inputs
// ************************************************************
module pvc_core_model (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic core_fast_request_n,
    input wire logic core_normal_request_n,
    output logic [7:0] fast_cnt,
    output logic [7:0] norm_cnt
);
    logic fast_q;
    logic norm_q;

    // both inputs are active low; a request starts on a falling edge
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            fast_q <= 1'b1;
            norm_q <= 1'b1;
            fast_cnt <= 8'h00;
            norm_cnt <= 8'h00;
        end else begin
            fast_q <= core_fast_request_n;
            norm_q <= core_normal_request_n;
            if (fast_q && !core_fast_request_n) begin
                fast_cnt <= fast_cnt + 8'h01;
            end
            if (norm_q && !core_normal_request_n) begin
                norm_cnt <= norm_cnt + 8'h01;
            end
        end
    end
endmodule

// *** tb/vectored_priority_interrupt_ctrl_bench.sv ***
`timescale 1ns/100ps
module vectored_priority_interrupt_ctrl_bench;
    import pvc_pkg::*;
    localparam logic [31:0] BASE = 32'hfff8_3f00;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel, penable, pwrite, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata;
    logic [NUM_INT-1:0] periph_irq;
    logic ext0, ext1, fast_pin, core_fast_request_n, core_normal_request_n, irq;
    logic [7:0] fast_cnt, norm_cnt;
    int n_errors = 0;
    int tests_run = 0;

    always #4 ref_clk = ~ref_clk;

    pvc_top u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .periph_irq(periph_irq), .ext_request_pin_zero(ext0),
        .ext_request_pin_one(ext1), .fast_request_pin(fast_pin),
        .core_fast_request_n(core_fast_request_n), .core_normal_request_n(core_normal_request_n),
        .irq(irq));

    pvc_core_model u_core (.ref_clk(ref_clk), .rst_n(rst_n), .core_fast_request_n(core_fast_request_n),
        .core_normal_request_n(core_normal_request_n), .fast_cnt(fast_cnt), .norm_cnt(norm_cnt));

    // ************************************************************
    // helpers
    // ************************************************************
    task conclude;
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    // request held until pready is seen at a rising edge
    task apb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r,
        output logic e);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        n = 0;
        while (pready !== 1'b1 && n < 50) begin
            @(posedge ref_clk);
            n++;
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) chk(32'h0, 32'h1, "no pready");
    endtask

    task wr(input logic [7:0] ofs, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, BASE + {24'h0, ofs}, d, r, e);
        chk({31'h0, e}, 32'h0, "write error");
    endtask

    task rd(input logic [7:0] ofs, input logic [31:0] exp, input string msg);
        logic [31:0] r;
        logic e;
        apb(1'b0, BASE + {24'h0, ofs}, 32'h0, r, e);
        chk({31'h0, e}, 32'h0, "read error");
        chk(r, exp, msg);
    endtask

    task bad(input logic w, input logic [31:0] a);
        logic [31:0] r;
        logic e;
        apb(w, a, 32'h1, r, e);
        chk({31'h0, e}, 32'h1, "missing slave error");
    endtask

    // core outputs settle one cycle after the pending/enable change
    task pins(input logic f, input logic nrm, input string msg);
        repeat (3) @(posedge ref_clk);
        chk({30'h0, core_fast_request_n, core_normal_request_n}, {30'h0, f, nrm}, msg);
        chk({31'h0, irq}, {31'h0, ~nrm}, "irq level");
    endtask

    task setpin(input int p, input logic v);
        if (p == 0) ext0 <= v;
        else ext1 <= v;
    endtask

    function automatic logic [7:0] mofs(input int i);
        return 8'(4 * i);
    endfunction

    function automatic logic [31:0] vec(input int i, input int l);
        return 32'h8000_0000 | 32'(l << 4) | 32'(i);
    endfunction

    // ************************************************************
    // tests
    // ************************************************************
    initial begin
        logic [1:0] mm;
        logic [31:0] bit_p;
        psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        periph_irq = '0; ext0 = 1; ext1 = 1; fast_pin = 1;
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        pins(1'b1, 1'b1, "reset outputs");
        rd(OFS_EN, 32'h0, "enable reset");
        rd(OFS_PEND, 32'h0, "pending reset");
        rd(mofs(16), 32'h0, "mode reset");
        bad(1'b0, 32'hfff8_0000);
        bad(1'b0, 32'hfff7_3f00);
        bad(1'b0, BASE + 32'h60);
        bad(1'b0, BASE + 32'h2);
        bad(1'b1, 32'hfff4_3f58);
        rd(OFS_EN, 32'h0, "stray write landed");
        wr(OFS_EN_SET, 32'h5);
        rd(OFS_EN, 32'h5, "set alias");
        wr(OFS_EN_SET, 32'h2);
        rd(OFS_EN, 32'h7, "set keeps others");
        wr(OFS_EN_CLR, 32'h1);
        rd(OFS_EN, 32'h6, "clear alias");
        wr(OFS_EN_CLR, 32'h0);
        rd(OFS_EN, 32'h6, "zero clear");
        rd(OFS_EN_SET, 32'h0, "write-only reads zero");
        wr(OFS_EN_CLR, 32'h6);
        // level internal source
        periph_irq[0] <= 1'b1;
        wr(OFS_EN_SET, 32'h1);
        pins(1'b1, 1'b0, "peripheral level request");
        wr(OFS_PEND_CLR, 32'h1);
        rd(OFS_PEND, 32'h1, "level not clearable");
        wr(OFS_EN_CLR, 32'h1);
        pins(1'b1, 1'b1, "masked source");
        periph_irq[0] <= 1'b0;
        rd(OFS_PEND, 32'h0, "level follows pin");
        // edge internal source, then an edge on the very edge a clear lands
        wr(mofs(0), 32'h20);
        periph_irq[0] <= 1'b1;
        @(posedge ref_clk);
        periph_irq[0] <= 1'b0;
        rd(OFS_PEND, 32'h1, "edge sticky");
        fork
            wr(OFS_PEND_CLR, 32'h1);
            begin
                repeat (2) @(posedge ref_clk);
                periph_irq[0] <= 1'b1;
            end
        join
        periph_irq[0] <= 1'b0;
        rd(OFS_PEND, 32'h1, "edge beats clear");
        wr(OFS_PEND_CLR, 32'h1);
        rd(OFS_PEND, 32'h0, "edge cleared");
        // priority and vector
        wr(mofs(2), 32'h25);
        wr(mofs(9), 32'h25);
        rd(mofs(9), 32'h25, "mode readback");
        wr(OFS_EN_SET, 32'h204);
        wr(OFS_PEND_SET, 32'h204);
        rd(OFS_VEC, vec(2, 5), "tie to lowest index");
        wr(mofs(11), 32'h26);
        wr(OFS_PEND_SET, 32'h800);
        rd(OFS_VEC, vec(2, 5), "masked source won");
        wr(OFS_EN_SET, 32'h800);
        rd(OFS_VEC, vec(11, 6), "higher level wins");
        pins(1'b1, 1'b0, "normal request");
        wr(OFS_PEND_CLR, 32'h804);
        rd(OFS_VEC, vec(9, 5), "next in line");
        wr(OFS_PEND_CLR, 32'h200);
        pins(1'b1, 1'b1, "all cleared");
        chk({24'h0, norm_cnt}, 32'h2, "normal request count");
        // external pins, all four sensitivities each
        wr(OFS_EN_SET, 32'hc000);
        for (int p = 0; p < 2; p++) begin
            bit_p = 32'h1 << (14 + p);
            for (int m = 0; m < 4; m++) begin
                mm = 2'(m);
                setpin(p, ~mm[0]);
                wr(mofs(14 + p), {26'h0, mm, 4'h0});
                wr(OFS_PEND_CLR, bit_p);
                rd(OFS_PEND, 32'h0, "inactive pin");
                setpin(p, mm[0]);
                pins(1'b1, 1'b0, "external request");
                setpin(p, ~mm[0]);
                pins(1'b1, ~mm[1], "external release");
                rd(OFS_PEND, mm[1] ? bit_p : 32'h0, "external pending");
                wr(OFS_PEND_CLR, bit_p);
                pins(1'b1, 1'b1, "external cleared");
            end
        end
        chk({24'h0, fast_cnt}, 32'h0, "fast from other source");
        // fast pin, rising edge
        wr(mofs(16), 32'h30);
        fast_pin <= 1'b0;
        wr(OFS_PEND_CLR, 32'h10000);
        wr(OFS_EN_SET, 32'h10000);
        rd(OFS_PEND, 32'h0, "falling ignored");
        fast_pin <= 1'b1;
        pins(1'b0, 1'b1, "fast request only");
        // the core model counts on the edge the request is first seen low
        @(posedge ref_clk);
        chk({24'h0, fast_cnt}, 32'h1, "fast request count");
        wr(OFS_PEND_CLR, 32'h10000);
        pins(1'b1, 1'b1, "fast cleared");
        conclude;
    end

    // whole run needs well under 5000 cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        conclude;
    end
endmodule
